// File: src/tcs_pkg.sv
// constants and types shared by the timer channel count sequencer
package tcs_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_RELOAD = 8'h08;
   localparam logic [7:0] ADDR_COUNT = 8'h0C;
   localparam int START_BIT = 0;
   localparam int STOP_BIT = 1;
   localparam int EN_BIT = 0;
   localparam int WAIT_BIT = 1;
   localparam int CFG_W = 12;
   localparam int PRESC_W = 15;
   localparam logic [2:0] MODE_INTERVAL = 3'h0;
   localparam logic [2:0] MODE_EVENT = 3'h1;
   localparam logic [2:0] MODE_CAPTURE = 3'h2;
   localparam logic [2:0] MODE_ONECOUNT = 3'h3;
   localparam logic [2:0] MODE_CAPONE = 3'h4;
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_FULL = 16'hFFFF;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] RELOAD_RST = 16'h0000;

   // configuration word, bit 0 is the low bit of mode
   typedef struct packed {
      logic [3:0] prescaler_select;
      logic filter_en;
      logic [1:0] edge_sel;
      logic count_source_select;
      logic start_interrupt_select;
      logic [2:0] mode;
   } tcs_cfg_type;

   localparam tcs_cfg_type CFG_RST = tcs_cfg_type'(12'h000);

   typedef struct packed {
      logic rise;
      logic fall;
   } tcs_edge_type;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_CLK, ST_WAIT_TRIG, ST_RUN} tcs_state_type;
endpackage

// File: src/tcs_edge_detect.sv
// timer input sampler with optional noise filter and edge pulses
module tcs_edge_detect import tcs_pkg::*; (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic mck_en_i,
   input wire logic pin_i,
   input wire logic filter_en_i,
   output tcs_edge_type edge_o
);
   logic smp_reg;
   logic dly1_reg;
   logic dly2_reg;
   logic lvl_reg;
   tcs_edge_type edge_reg;

   // filtered level moves only after three equal samples: two extra operation clocks
   wire logic agree = (smp_reg == dly1_reg) && (dly1_reg == dly2_reg);
   wire logic lvl_next = filter_en_i ? (agree ? dly2_reg : lvl_reg) : smp_reg;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         smp_reg <= 1'b0;
         dly1_reg <= 1'b0;
         dly2_reg <= 1'b0;
         lvl_reg <= 1'b0;
         edge_reg <= '0;
      end else begin
         edge_reg <= '0;
         if (mck_en_i) begin
            smp_reg <= pin_i;
            dly1_reg <= smp_reg;
            dly2_reg <= dly1_reg;
            lvl_reg <= lvl_next;
            edge_reg.rise <= lvl_next & ~lvl_reg;
            edge_reg.fall <= ~lvl_next & lvl_reg;
         end
      end
   end

   assign edge_o = edge_reg;
endmodule // tcs_edge_detect

// File: src/tcs_channel.sv
// one 16-bit timer channel counter with apb registers
//
// The APB slave port and the address map were chosen for this implementation.
module tcs_channel import tcs_pkg::*; (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic timer_input_pin_i,
   output logic channel_interrupt_o,
   output logic channel_enabled_flag_o
);
   tcs_cfg_type cfg_reg;
   tcs_state_type st_reg;
   logic [15:0] channel_counter_reg;
   logic [15:0] reload_capture_value_reg;
   logic [PRESC_W-1:0] presc_reg;
   logic mck_reg;
   logic en_reg;
   logic irq_reg;
   logic trig_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   tcs_edge_type edge_w;

   // apb decode: one wait state, data and ready registered
   wire logic acc_first = psel_i & penable_i & ~pready_reg;
   wire logic wr = psel_i & penable_i & pready_reg & pwrite_i;
   wire logic hit_ctrl = (paddr_i == ADDR_CTRL);
   wire logic hit_cfg = (paddr_i == ADDR_CFG);
   wire logic hit_reload = (paddr_i == ADDR_RELOAD);
   wire logic hit_count = (paddr_i == ADDR_COUNT);
   wire logic mapped = hit_ctrl | hit_cfg | hit_reload | hit_count;
   wire logic wr_ctrl = wr & hit_ctrl;
   wire logic stop_wr = wr_ctrl & pwdata_i[STOP_BIT];
   wire logic start_wr = wr_ctrl & pwdata_i[START_BIT] & ~pwdata_i[STOP_BIT];
   wire logic [31:0] rd_mux =
      hit_ctrl ? {30'h0, (st_reg == ST_WAIT_TRIG), en_reg} :
      hit_cfg ? {20'h0, cfg_reg} :
      hit_reload ? {16'h0, reload_capture_value_reg} :
      hit_count ? {16'h0, channel_counter_reg} : 32'h0;

   // prescaler: a one-clock pulse every 2^select clocks
   wire logic [PRESC_W-1:0] presc_mask = PRESC_W'((16'h0001 << cfg_reg.prescaler_select) - 16'h0001);
   wire logic mck_next = ((presc_reg & presc_mask) == presc_mask);

   tcs_edge_detect u_edge (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .mck_en_i(mck_reg),
      .pin_i(timer_input_pin_i),
      .filter_en_i(cfg_reg.filter_en),
      .edge_o(edge_w)
   );

   wire logic edge_v = (cfg_reg.edge_sel == EDGE_RISE) ? edge_w.rise :
                       (cfg_reg.edge_sel == EDGE_FALL) ? edge_w.fall : (edge_w.rise | edge_w.fall);
   wire logic cclk = cfg_reg.count_source_select ? edge_v : mck_reg;
   wire logic [2:0] md = cfg_reg.mode;
   wire logic one_md = (md == MODE_ONECOUNT) | (md == MODE_CAPONE);
   wire logic at_zero = (channel_counter_reg == COUNT_ZERO);

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         presc_reg <= '0;
         mck_reg <= 1'b0;
      end else begin
         presc_reg <= presc_reg + PRESC_W'(1);
         mck_reg <= mck_next;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
         cfg_reg <= CFG_RST;
      end else begin
         pready_reg <= acc_first;
         if (acc_first) begin
            pslverr_reg <= ~mapped;
            prdata_reg <= pwrite_i ? 32'h0 : rd_mux;
         end
         if (wr & hit_cfg) begin
            cfg_reg <= tcs_cfg_type'(pwdata_i[CFG_W-1:0]);
         end
      end
   end

   // channel sequencer; counter changes the clock after the count pulse
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_reg <= ST_IDLE;
         en_reg <= 1'b0;
         irq_reg <= 1'b0;
         trig_reg <= 1'b0;
         channel_counter_reg <= COUNT_RST;
         reload_capture_value_reg <= RELOAD_RST;
      end else begin
         irq_reg <= 1'b0;
         trig_reg <= 1'b0;
         if (wr & hit_reload) begin
            reload_capture_value_reg <= pwdata_i[15:0];
         end
         if (stop_wr) begin
            en_reg <= 1'b0;
            st_reg <= ST_IDLE;
         end else if (start_wr && !(one_md && en_reg)) begin
            en_reg <= 1'b1;
            if (md == MODE_EVENT) begin
               channel_counter_reg <= reload_capture_value_reg;
               st_reg <= ST_RUN;
            end else if (one_md) begin
               st_reg <= ST_WAIT_TRIG;
            end else begin
               st_reg <= ST_WAIT_CLK;
            end
         end else begin
            case (st_reg)
               ST_WAIT_CLK: begin
                  if (cclk) begin
                     trig_reg <= 1'b1;
                     irq_reg <= cfg_reg.start_interrupt_select;
                     st_reg <= ST_RUN;
                     if (md == MODE_CAPTURE) begin
                        channel_counter_reg <= COUNT_ZERO;
                     end else begin
                        channel_counter_reg <= reload_capture_value_reg;
                     end
                  end
               end
               ST_WAIT_TRIG: begin
                  if (edge_w.rise) begin
                     trig_reg <= 1'b1;
                     st_reg <= ST_RUN;
                     if (md == MODE_CAPONE) begin
                        channel_counter_reg <= COUNT_ZERO;
                     end else begin
                        channel_counter_reg <= reload_capture_value_reg;
                     end
                  end
               end
               ST_RUN: begin
                  if (md == MODE_CAPTURE) begin
                     if (edge_v) begin
                        reload_capture_value_reg <= channel_counter_reg;
                        irq_reg <= 1'b1;
                        channel_counter_reg <= COUNT_ZERO;
                     end else if (cclk) begin
                        channel_counter_reg <= channel_counter_reg + 16'h0001;
                     end
                  end else if (md == MODE_CAPONE) begin
                     if (edge_w.fall) begin
                        reload_capture_value_reg <= channel_counter_reg;
                        irq_reg <= 1'b1;
                        st_reg <= ST_WAIT_TRIG;
                     end else if (cclk) begin
                        channel_counter_reg <= channel_counter_reg + 16'h0001;
                     end
                  end else if (cclk) begin
                     if (!at_zero) begin
                        channel_counter_reg <= channel_counter_reg - 16'h0001;
                     end else if (md == MODE_ONECOUNT) begin
                        irq_reg <= 1'b1;
                        channel_counter_reg <= COUNT_FULL;
                        st_reg <= ST_WAIT_TRIG;
                     end else begin
                        irq_reg <= 1'b1;
                        channel_counter_reg <= reload_capture_value_reg;
                     end
                  end
               end
               default: begin
                  st_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign channel_interrupt_o = irq_reg;
   assign channel_enabled_flag_o = en_reg;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   wire logic quiet = ~wr_ctrl;

   property p_start_en;
      start_wr && md == MODE_INTERVAL |=> en_reg && st_reg == ST_WAIT_CLK && $stable(channel_counter_reg);
   endproperty
   a_start_en: assert property (p_start_en) else $error("start did not enable channel");

   property p_first_load;
      quiet && st_reg == ST_WAIT_CLK && cclk && md == MODE_INTERVAL
         |=> channel_counter_reg == $past(reload_capture_value_reg) && st_reg == ST_RUN;
   endproperty
   a_first_load: assert property (p_first_load) else $error("first count clock did not load reload");

   property p_start_irq;
      quiet && st_reg == ST_WAIT_CLK && cclk && cfg_reg.start_interrupt_select |=> irq_reg && trig_reg;
   endproperty
   a_start_irq: assert property (p_start_irq) else $error("missing start interrupt");

   property p_wrap;
      quiet && st_reg == ST_RUN && md == MODE_INTERVAL && cclk && at_zero
         |=> irq_reg && channel_counter_reg == $past(reload_capture_value_reg);
   endproperty
   a_wrap: assert property (p_wrap) else $error("interval wrap wrong");

   property p_evt_load;
      start_wr && md == MODE_EVENT |=> channel_counter_reg == $past(reload_capture_value_reg) && en_reg;
   endproperty
   a_evt_load: assert property (p_evt_load) else $error("event start did not load");

   property p_capture;
      quiet && st_reg == ST_RUN && md == MODE_CAPTURE && edge_v
         |=> irq_reg && channel_counter_reg == COUNT_ZERO && reload_capture_value_reg == $past(channel_counter_reg);
   endproperty
   a_capture: assert property (p_capture) else $error("capture wrong");

   property p_one_end;
      quiet && st_reg == ST_RUN && md == MODE_ONECOUNT && cclk && at_zero
         |=> irq_reg && channel_counter_reg == COUNT_FULL && st_reg == ST_WAIT_TRIG;
   endproperty
   a_one_end: assert property (p_one_end) else $error("one-count end wrong");

   property p_wait_hold;
      quiet && st_reg == ST_WAIT_TRIG && !edge_w.rise |=> $stable(channel_counter_reg);
   endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("counter moved while waiting");

   property p_pulse;
      irq_reg |=> !irq_reg;
   endproperty
   a_pulse: assert property (p_pulse) else $error("interrupt longer than one clock");

   property p_stop;
      stop_wr |=> !en_reg ##1 (st_reg == ST_IDLE && $stable(channel_counter_reg));
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not freeze");

   property p_evt_count;
      quiet && st_reg == ST_RUN && md == MODE_EVENT && cfg_reg.count_source_select && edge_v && !at_zero
         |=> channel_counter_reg == $past(channel_counter_reg) - 16'h0001;
   endproperty
   a_evt_count: assert property (p_evt_count) else $error("event edge did not count down");

   property p_cap_start;
      quiet && st_reg == ST_WAIT_CLK && md == MODE_CAPTURE && cclk
         |=> channel_counter_reg == COUNT_ZERO && st_reg == ST_RUN;
   endproperty
   a_cap_start: assert property (p_cap_start) else $error("capture start did not clear counter");

   property p_cap_step;
      quiet && st_reg == ST_RUN && md == MODE_CAPTURE && cclk && !edge_v
         |=> channel_counter_reg == $past(channel_counter_reg) + 16'h0001;
   endproperty
   a_cap_step: assert property (p_cap_step) else $error("capture count did not step up");

   property p_one_load;
      quiet && st_reg == ST_WAIT_TRIG && md == MODE_ONECOUNT && edge_w.rise
         |=> channel_counter_reg == $past(reload_capture_value_reg) && st_reg == ST_RUN;
   endproperty
   a_one_load: assert property (p_one_load) else $error("rising edge did not load reload");

   property p_capone_load;
      quiet && st_reg == ST_WAIT_TRIG && md == MODE_CAPONE && edge_w.rise
         |=> channel_counter_reg == COUNT_ZERO && st_reg == ST_RUN;
   endproperty
   a_capone_load: assert property (p_capone_load) else $error("rising edge did not clear counter");

   property p_width;
      quiet && st_reg == ST_RUN && md == MODE_CAPONE && edge_w.fall
         |=> irq_reg && reload_capture_value_reg == $past(channel_counter_reg);
   endproperty
   a_width: assert property (p_width) else $error("falling edge did not capture width");

   c_wrap: cover property (st_reg == ST_RUN && md == MODE_INTERVAL && cclk && at_zero);
   c_capture: cover property (st_reg == ST_RUN && md == MODE_CAPTURE && edge_v);
   c_capone: cover property (st_reg == ST_RUN && md == MODE_CAPONE && edge_w.fall);
   c_event: cover property (st_reg == ST_RUN && md == MODE_EVENT && edge_v);
   c_one_end: cover property (st_reg == ST_RUN && md == MODE_ONECOUNT && cclk && at_zero);
endmodule // tcs_channel

// File: testbench/tcs_pin_model.sv
// behavioural source of the timer input pin, synchronous to the clock
module tcs_pin_model (
   input wire logic clock_i,
   output logic pin_o
);
   timeunit 1ns;
   timeprecision 1ns;

   initial pin_o = 1'b0;

   // n pulses, each lo cycles low then hi cycles high; the pin idles low
   task automatic pulses(input int n, input int hi, input int lo);
      for (int k = 0; k < n; k++) begin
         repeat (lo) @(posedge clock_i);
         pin_o <= 1'b1;
         repeat (hi) @(posedge clock_i);
         pin_o <= 1'b0;
      end
   endtask
endmodule // tcs_pin_model

// File: testbench/tb_top.sv
// self-checking bench for the timer channel count sequencer
module tb_top import tcs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pin;
   logic irq;
   logic en;
   logic pin_d = 1'b0;
   logic [31:0] rdat;
   logic [31:0] c;
   logic err;
   int cyc = 0;
   int failures = 0;
   int cmp_count = 0;
   int t0 = 0;
   int lat[2];
   int irq_q[$];
   int rise_q[$];

   always #25 clock = ~clock;

   tcs_channel i_tcs_channel (.clock_i(clock), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .timer_input_pin_i(pin), .channel_interrupt_o(irq), .channel_enabled_flag_o(en));

   tcs_pin_model i_tcs_pin_model (.clock_i(clock), .pin_o(pin));

   // time stamps of pin rises and interrupt pulses, in clock cycles
   always @(posedge clock) begin
      cyc <= cyc + 1;
      pin_d <= pin;
      if (pin === 1'b1 && pin_d === 1'b0) rise_q.push_back(cyc);
      if (irq === 1'b1) irq_q.push_back(cyc);
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h00000000);
   endtask

   function automatic logic [31:0] cfgw(logic [2:0] m, logic s, logic cs, logic f, logic [3:0] p);
      tcs_cfg_type t;
      t = '{p, f, EDGE_RISE, cs, s, m};
      return {20'h00000, t};
   endfunction

   task automatic complete_run;
      $display("checks %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      complete_run;
   end

   initial begin
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         rd(8'(4 * k));
         chk("reset value", 32'h00000000, rdat);
      end
      rd(8'h10);
      chk("unmapped error", 32'h00000001, {31'h00000000, err});
      wr(ADDR_COUNT, 32'h00001234);
      rd(ADDR_COUNT);
      chk("count read only", 32'h00000000, rdat);
      // interval: slow prescaler so no count clock comes before the reads
      wr(ADDR_CFG, cfgw(MODE_INTERVAL, 1'b1, 1'b0, 1'b0, 4'hF));
      wr(ADDR_RELOAD, 32'h00000003);
      wr(ADDR_CTRL, 32'h00000001);
      rd(ADDR_CTRL);
      chk("enabled", 32'h00000001, rdat);
      chk("enabled pin", 32'h00000001, {31'h00000000, en});
      rd(ADDR_COUNT);
      chk("count held", 32'h00000000, rdat);
      wr(ADDR_CTRL, 32'h00000002);
      wr(ADDR_CFG, cfgw(MODE_INTERVAL, 1'b1, 1'b0, 1'b0, 4'h1));
      irq_q.delete();
      wr(ADDR_CTRL, 32'h00000001);
      t0 = cyc;
      repeat (40) @(posedge clock);
      wr(ADDR_CTRL, 32'h00000002);
      chk("interval irqs", 32'h00000001, 32'(irq_q.size() >= 4));
      chk("start irq time", 32'h00000001, 32'((irq_q[0] - t0 == 2) || (irq_q[0] - t0 == 3)));
      for (int k = 1; k < irq_q.size(); k++) chk("irq period", 32'h00000008, 32'(irq_q[k] - irq_q[k-1]));
      rd(ADDR_COUNT);
      c = rdat;
      repeat (10) @(posedge clock);
      rd(ADDR_COUNT);
      chk("count frozen", c, rdat);
      rd(ADDR_CTRL);
      chk("stopped", 32'h00000000, rdat);
      chk("enabled pin off", 32'h00000000, {31'h00000000, en});
      // event counter on rising input edges
      wr(ADDR_CFG, cfgw(MODE_EVENT, 1'b0, 1'b1, 1'b0, 4'h0));
      wr(ADDR_RELOAD, 32'h00000005);
      wr(ADDR_CTRL, 32'h00000001);
      rd(ADDR_COUNT);
      chk("event load", 32'h00000005, rdat);
      i_tcs_pin_model.pulses(2, 4, 4);
      repeat (6) @(posedge clock);
      rd(ADDR_COUNT);
      chk("event count", 32'h00000003, rdat);
      wr(ADDR_CTRL, 32'h00000002);
      // capture, without and with the noise filter
      for (int f = 0; f < 2; f++) begin
         wr(ADDR_CFG, cfgw(MODE_CAPTURE, 1'b0, 1'b0, f[0], 4'h0));
         wr(ADDR_CTRL, 32'h00000001);
         irq_q.delete();
         rise_q.delete();
         i_tcs_pin_model.pulses(3, 10, 10);
         repeat (10) @(posedge clock);
         lat[f] = irq_q[0] - rise_q[0];
         for (int k = 1; k < 3; k++) chk("capture period", 32'h00000014, 32'(irq_q[k] - irq_q[k-1]));
         rd(ADDR_RELOAD);
         chk("capture value", 32'h00000013, rdat);
         wr(ADDR_CTRL, 32'h00000002);
      end
      chk("filter delay", 32'h00000002, 32'(lat[1] - lat[0]));
      // one-count: wait for a rising edge, count down, end at all ones
      wr(ADDR_CFG, cfgw(MODE_ONECOUNT, 1'b0, 1'b0, 1'b0, 4'h0));
      wr(ADDR_RELOAD, 32'h00000004);
      rd(ADDR_COUNT);
      c = rdat;
      wr(ADDR_CTRL, 32'h00000001);
      rd(ADDR_CTRL);
      chk("waiting", 32'h00000003, rdat);
      rd(ADDR_COUNT);
      chk("count waiting", c, rdat);
      wr(ADDR_CTRL, 32'h00000001);
      irq_q.delete();
      rise_q.delete();
      i_tcs_pin_model.pulses(1, 4, 4);
      repeat (12) @(posedge clock);
      chk("one-count irqs", 32'h00000001, 32'(irq_q.size()));
      chk("one-count span", 32'(lat[0] + 5), 32'(irq_q[0] - rise_q[0]));
      rd(ADDR_COUNT);
      chk("one-count end", 32'h0000FFFF, rdat);
      wr(ADDR_CTRL, 32'h00000002);
      // high width measurement
      wr(ADDR_CFG, cfgw(MODE_CAPONE, 1'b0, 1'b0, 1'b0, 4'h0));
      wr(ADDR_CTRL, 32'h00000001);
      irq_q.delete();
      rise_q.delete();
      i_tcs_pin_model.pulses(1, 12, 4);
      repeat (10) @(posedge clock);
      chk("width irqs", 32'h00000001, 32'(irq_q.size()));
      chk("width irq time", 32'(lat[0] + 12), 32'(irq_q[0] - rise_q[0]));
      rd(ADDR_RELOAD);
      chk("high width", 32'h0000000B, rdat);
      complete_run;
   end
endmodule // tb_top
